// ### hw/hrd_pkg.sv
// constants for the receive descriptor status write-back block
`default_nettype none
package hrd_pkg;
  // descriptor status word bit positions
  localparam int BIT_EMPTY = 0;
  localparam int BIT_WRAP = 2;
  localparam int BIT_ALARM = 3;
  localparam int BIT_LAST = 4;
  localparam int BIT_FIRST = 5;
  localparam int BIT_CONT = 6;
  localparam int BIT_USER = 8;
  localparam int BIT_OVERSIZE = 10;
  localparam int BIT_NONOCTET = 11;
  localparam int BIT_BREAK = 12;
  localparam int BIT_CRCERR = 13;
  localparam int BIT_CDLOST = 14;
  localparam int BIT_DATALOST = 15;
  localparam int LEN_LSB = 16;
  localparam int LEN_W = 16;
  localparam int WORD_BYTES = 4;
  localparam logic [1:0] WORD_MASK = 2'h3;
  localparam logic [15:0] LIMIT_RST = 16'h0640;
  typedef enum logic [1:0] {
    HRD_IDLE,
    HRD_RECV,
    HRD_DISCARD,
    HRD_CLOSE
  } hrd_state_t;
endpackage : hrd_pkg
`default_nettype wire

// ### hw/hrd_len_guard.sv
// byte counter with word-rounded storage limit for one frame
`default_nettype none
module hrd_len_guard #(
  parameter int W = 16
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic byte_in,
  input wire logic [W-1:0] limit,
  output logic [W-1:0] count,
  output logic store_ok,
  output logic over
);
  logic [W-1:0] cap;
  // store cap is the limit rounded up to a whole word
  assign cap = (limit + W'(hrd_pkg::WORD_MASK)) & ~W'(hrd_pkg::WORD_MASK);
  // bytes past the cap are counted but never written
  assign store_ok = (count < cap);

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= byte_in ? W'(1) : '0;
    end else if (byte_in) begin
      count <= count + W'(1);
    end
  end

  // flagged once count passes limit and a word boundary is reached
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      over <= 1'b0;
    end else if (clear) begin
      over <= 1'b0;
    end else if (count > limit && ((count & W'(hrd_pkg::WORD_MASK)) == '0 || count >= cap)) begin
      over <= 1'b1;
    end
  end
endmodule : hrd_len_guard
`default_nettype wire

// ### hw/hrd_rx_status.sv
// receive descriptor status write-back for one hdlc channel
// Functional notes
// - alarm bit clear: no buffer-used event; frame event still reported.
// - alarm bit set: post buffer-used and, in hdlc mode, frame event.
// - hdlc mode: set last-in-frame on closing flag or error end.
// - error end sets at least one of carrier, data-lost, break, oversize.
// - closing final buffer writes frame octet count into data_length.
// - first-in-frame set on buffer holding frame start, else clear.
// - continuous mode keeps the owning flag set after close.
// - continuous mode keeps owning flag set even after errors.
// - software-owned bit is never modified by the device.
// - oversize frame stores only limit bytes rounded up to a word.
// - length violation detected at word write, within three byte times.
// - after violation discard until flag, close with oversize error.
// - oversize data_length counts all bytes between the flags.
// - clear owning flag when buffer filled or aborted; skip it while clear.
// - last descriptor length includes the crc octets.
`default_nettype none
module hrd_rx_status #(
  parameter int LEN_W = 16,
  parameter int BUF_BYTES = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hdlc_mode,
  input wire logic [LEN_W-1:0] max_frame_length_limit,
  input wire logic frame_start,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic closing_flag,
  input wire logic err_carrier,
  input wire logic err_data_lost,
  input wire logic err_break,
  input wire logic bd_valid,
  input wire logic [31:0] bd_status_in,
  output logic bd_fetch,
  output logic mem_we,
  output logic [7:0] mem_data,
  output logic [LEN_W-1:0] mem_offset,
  output logic bd_we,
  output logic [31:0] bd_status_out,
  output logic buffer_used_event,
  output logic frame_received_event
);
  hrd_pkg::hrd_state_t state_r;
  logic [31:0] bd_r;
  logic first_r;
  logic last_c;
  logic err_c;
  logic full_c;
  logic [LEN_W-1:0] frame_cnt;
  logic [LEN_W-1:0] buf_cnt_r;
  logic store_ok;
  logic over;
  logic frame_clear;

  assign err_c = err_carrier | err_data_lost | err_break;
  assign frame_clear = frame_start && state_r != hrd_pkg::HRD_CLOSE;
  // a byte within two clocks of filling a buffer is lost; channel bytes come wider apart
  assign full_c = (buf_cnt_r == LEN_W'(BUF_BYTES));

  hrd_len_guard #(.W(LEN_W)) u_guard (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(frame_clear),
    .byte_in(byte_valid),
    .limit(max_frame_length_limit),
    .count(frame_cnt),
    .store_ok(store_ok),
    .over(over)
  );

  // a descriptor is requested on every frame start in idle; it is taken only while its owning flag is set
  assign bd_fetch = (state_r == hrd_pkg::HRD_IDLE) && frame_start;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r <= hrd_pkg::HRD_IDLE;
      bd_r <= '0;
      first_r <= 1'b0;
      last_c <= 1'b0;
    end else begin
      case (state_r)
        hrd_pkg::HRD_IDLE: begin
          if (bd_fetch && bd_valid && bd_status_in[hrd_pkg::BIT_EMPTY]) begin
            bd_r <= bd_status_in;
            first_r <= 1'b1;
            state_r <= hrd_pkg::HRD_RECV;
          end
        end
        hrd_pkg::HRD_RECV: begin
          if (over) begin
            state_r <= hrd_pkg::HRD_DISCARD;
          end else if (closing_flag || err_c) begin
            last_c <= 1'b1;
            state_r <= hrd_pkg::HRD_CLOSE;
          end else if (full_c) begin
            last_c <= 1'b0;
            state_r <= hrd_pkg::HRD_CLOSE;
          end
        end
        hrd_pkg::HRD_DISCARD: begin
          // any flag ends discard and is taken as the closing flag
          if (closing_flag || err_c) begin
            last_c <= 1'b1;
            state_r <= hrd_pkg::HRD_CLOSE;
          end
        end
        hrd_pkg::HRD_CLOSE: begin
          first_r <= 1'b0;
          // a next buffer still held by software is not reused
          if (!last_c && bd_valid && bd_status_in[hrd_pkg::BIT_EMPTY]) begin
            bd_r <= bd_status_in;
            state_r <= hrd_pkg::HRD_RECV;
          end else begin
            state_r <= hrd_pkg::HRD_IDLE;
          end
        end
        default: state_r <= hrd_pkg::HRD_IDLE;
      endcase
    end
  end

  // per-buffer byte count and store path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_cnt_r <= '0;
      mem_we <= 1'b0;
      mem_data <= '0;
      mem_offset <= '0;
    end else begin
      // bytes beyond the rounded limit are dropped
      mem_we <= byte_valid && store_ok && state_r == hrd_pkg::HRD_RECV && !full_c;
      mem_data <= byte_data;
      mem_offset <= buf_cnt_r;
      if (state_r == hrd_pkg::HRD_CLOSE || bd_fetch) begin
        buf_cnt_r <= '0;
      end else if (byte_valid && state_r == hrd_pkg::HRD_RECV && store_ok && !full_c) begin
        buf_cnt_r <= buf_cnt_r + LEN_W'(1);
      end
    end
  end

  // one write carries status, length and owner hand-back
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bd_we <= 1'b0;
      bd_status_out <= '0;
      buffer_used_event <= 1'b0;
      frame_received_event <= 1'b0;
    end else begin
      bd_we <= 1'b0;
      buffer_used_event <= 1'b0;
      frame_received_event <= 1'b0;
      if (state_r == hrd_pkg::HRD_CLOSE) begin
        bd_we <= 1'b1;
        bd_status_out <= bd_r; // user bit passes untouched
        // continuous mode keeps ownership, even on error
        bd_status_out[hrd_pkg::BIT_EMPTY] <= bd_r[hrd_pkg::BIT_CONT];
        bd_status_out[hrd_pkg::BIT_FIRST] <= first_r;
        bd_status_out[hrd_pkg::BIT_LAST] <= last_c && hdlc_mode;
        bd_status_out[hrd_pkg::BIT_CDLOST] <= last_c && err_carrier;
        bd_status_out[hrd_pkg::BIT_DATALOST] <= last_c && err_data_lost;
        bd_status_out[hrd_pkg::BIT_BREAK] <= last_c && err_break;
        bd_status_out[hrd_pkg::BIT_OVERSIZE] <= last_c && over;
        bd_status_out[hrd_pkg::BIT_NONOCTET] <= 1'b0;
        bd_status_out[hrd_pkg::BIT_CRCERR] <= 1'b0;
        // last buffer reports whole frame incl. crc and discarded bytes
        bd_status_out[hrd_pkg::LEN_LSB +: hrd_pkg::LEN_W] <=
          last_c ? 16'(frame_cnt) : 16'(buf_cnt_r);
        buffer_used_event <= bd_r[hrd_pkg::BIT_ALARM];
        // in hdlc mode, frame event follows frame end regardless of alarm bit
        frame_received_event <= last_c && hdlc_mode;
      end
    end
  end

  chk_len_on_last: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && last_c) |=>
    bd_status_out[31:16] == $past(16'(frame_cnt)))
    else $error("closing length differs from frame count");
  chk_user_kept: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE) |=>
    bd_status_out[hrd_pkg::BIT_USER] == $past(bd_r[hrd_pkg::BIT_USER]))
    else $error("user bit altered");
  chk_cont_owner: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && bd_r[hrd_pkg::BIT_CONT]) |=>
    bd_we && bd_status_out[hrd_pkg::BIT_EMPTY])
    else $error("continuous buffer released");
  chk_norm_release: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && !bd_r[hrd_pkg::BIT_CONT]) |=>
    !bd_status_out[hrd_pkg::BIT_EMPTY])
    else $error("owner flag not cleared");
  chk_no_alarm: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && !bd_r[hrd_pkg::BIT_ALARM]) |=> !buffer_used_event)
    else $error("buffer event without alarm bit");
  chk_alarm_event: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && bd_r[hrd_pkg::BIT_ALARM]) |=> buffer_used_event && bd_we)
    else $error("missing buffer event");
  chk_err_last: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_RECV && !over && err_c && hdlc_mode) |=>
    ##1 bd_status_out[hrd_pkg::BIT_LAST])
    else $error("error end without last mark");
  chk_err_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (bd_we && bd_status_out[hrd_pkg::BIT_LAST] && !$past(closing_flag, 2)) |->
    (|bd_status_out[15:14] || bd_status_out[hrd_pkg::BIT_BREAK] ||
    bd_status_out[hrd_pkg::BIT_OVERSIZE]))
    else $error("error close without cause");
  chk_discard_store: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_DISCARD) |=> !mem_we)
    else $error("write during discard");
  chk_over_close: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_DISCARD && closing_flag) |=>
    ##1 bd_status_out[hrd_pkg::BIT_OVERSIZE])
    else $error("oversize not flagged");
  chk_over_lag: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_RECV && frame_cnt > max_frame_length_limit + LEN_W'(3)) |-> over)
    else $error("violation detected too late");
  chk_first_once: assert property (@(posedge ref_clk) disable iff (rst)
    (state_r == hrd_pkg::HRD_CLOSE && !first_r) |=> !bd_status_out[hrd_pkg::BIT_FIRST])
    else $error("first mark on later buffer");

  cov_normal: cover property (@(posedge ref_clk) disable iff (rst)
    bd_we && bd_status_out[hrd_pkg::BIT_LAST]);
  cov_oversize: cover property (@(posedge ref_clk) disable iff (rst)
    bd_we && bd_status_out[hrd_pkg::BIT_OVERSIZE]);
  cov_multibuf: cover property (@(posedge ref_clk) disable iff (rst)
    bd_we && !bd_status_out[hrd_pkg::BIT_LAST]);
  cov_cont: cover property (@(posedge ref_clk) disable iff (rst)
    bd_we && bd_status_out[hrd_pkg::BIT_CONT]);
endmodule : hrd_rx_status
`default_nettype wire

// ### tb/hrd_host_model.sv
// host software model that owns and recycles receive descriptors
`default_nettype none
module hrd_host_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic arm,
  input wire logic [31:0] arm_word,
  input wire logic stop_cont,
  input wire logic bd_we,
  input wire logic [31:0] bd_status_out,
  output logic bd_valid,
  output logic [31:0] bd_status_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] desc_r;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      desc_r <= 32'h0000_0000;
    end else if (arm) begin
      desc_r <= arm_word;
    end else if (stop_cont) begin
      desc_r[hrd_pkg::BIT_CONT] <= 1'b0;
    end else if (bd_we) begin
      // memory keeps what the device wrote, so reuse sees the written word
      desc_r <= bd_status_out;
    end
  end
  assign bd_valid = ~rst;
  assign bd_status_in = desc_r;
endmodule : hrd_host_model
`default_nettype wire

// ### tb/hrd_rx_status_test.sv
// self-checking bench for the receive descriptor status write-back block
`default_nettype none
module hrd_rx_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hdlc_mode = 1'b1;
  logic [15:0] lim = 16'h0040;
  logic frame_start = 1'b0;
  logic byte_valid = 1'b0;
  logic [7:0] byte_data = 8'h00;
  logic closing_flag = 1'b0;
  logic [2:0] err = 3'h0;
  logic arm = 1'b0;
  logic [31:0] arm_word = 32'h0;
  logic stop_cont = 1'b0;
  logic bd_valid, bd_fetch, mem_we, bd_we, ev_used, ev_frame;
  logic [31:0] bd_status_in, wb;
  logic [7:0] mem_data;
  logic [15:0] mem_offset;
  int errors = 0;
  int num_checks = 0;
  int stored = 0;
  int cycles = 0;
  int gap = 1;
  int writes = 0;
  logic [31:0] wb0 = 32'h0;
  logic used_seen = 1'b0;
  logic frame_seen = 1'b0;
  int eb[3] = '{hrd_pkg::BIT_CDLOST, hrd_pkg::BIT_DATALOST, hrd_pkg::BIT_BREAK};
  always #4 ref_clk = ~ref_clk;
  hrd_rx_status u_dut (.ref_clk(ref_clk), .rst(rst), .hdlc_mode(hdlc_mode),
    .max_frame_length_limit(lim), .frame_start(frame_start), .byte_valid(byte_valid),
    .byte_data(byte_data), .closing_flag(closing_flag), .err_carrier(err[0]),
    .err_data_lost(err[1]), .err_break(err[2]), .bd_valid(bd_valid),
    .bd_status_in(bd_status_in), .bd_fetch(bd_fetch), .mem_we(mem_we), .mem_data(mem_data),
    .mem_offset(mem_offset), .bd_we(bd_we), .bd_status_out(wb),
    .buffer_used_event(ev_used), .frame_received_event(ev_frame));
  hrd_host_model u_host (.ref_clk(ref_clk), .rst(rst), .arm(arm), .arm_word(arm_word),
    .stop_cont(stop_cont), .bd_we(bd_we), .bd_status_out(wb), .bd_valid(bd_valid),
    .bd_status_in(bd_status_in));
  task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : ck
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report
  // stored bytes must sit at their own offset, in order
  always @(posedge ref_clk) begin
    cycles++;
    if (mem_we === 1'b1) begin
      stored++;
      ck("mem_data", {24'h0, 8'h30 + mem_offset[7:0]}, {24'h0, mem_data});
    end
    // frame starts only come while idle, so each must ask for a descriptor
    if (frame_start === 1'b1) begin
      ck("bd_fetch", 32'h1, {31'h0, bd_fetch});
    end
    // events stand one cycle, so they are caught with the write they belong to
    if (bd_we === 1'b1) begin
      if (writes == 0) begin
        wb0 = wb;
      end
      writes++;
      used_seen = ev_used;
      frame_seen = ev_frame;
    end
    if (cycles == 3000) begin
      errors++;
      final_report();
    end
  end
  function automatic logic [31:0] mk(input logic own, alarm, cont, user);
    return {23'h0, user, 1'b0, cont, 2'h0, alarm, 2'h0, own};
  endfunction : mk
  // desc 0 reuses what memory holds; kind 0 ends by flag, else by error kind
  task automatic run(input logic [31:0] desc, input int n, input int kind, input logic want);
    int w;
    arm = (desc != 0);
    arm_word = desc;
    tick(1);
    arm = 1'b0;
    frame_start = 1'b1;
    stored = 0;
    writes = 0;
    used_seen = 1'b0;
    frame_seen = 1'b0;
    tick(1);
    frame_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      byte_valid = 1'b1;
      byte_data = 8'h30 + {2'h0, i[5:0]};
      tick(1);
      if (gap > 1) begin
        byte_valid = 1'b0;
        tick(gap - 1);
      end
    end
    byte_valid = 1'b0;
    closing_flag = (kind == 0);
    err = (kind == 0) ? 3'h0 : 3'(1 << (kind - 1));
    w = 0;
    while (bd_we !== 1'b1 && w < 20) begin
      tick(1);
      closing_flag = 1'b0;
      w++;
    end
    ck("bd_we", {31'h0, want}, {31'h0, bd_we});
    err = 3'h0;
    tick(2);
  endtask : run
  task automatic t_basic();
    run(mk(1, 1, 0, 1), 5, 0, 1);
    ck("stored", 5, stored);
    ck("owner", 0, wb[hrd_pkg::BIT_EMPTY]);
    ck("last", 1, wb[hrd_pkg::BIT_LAST]);
    ck("first", 1, wb[hrd_pkg::BIT_FIRST]);
    ck("user", 1, wb[hrd_pkg::BIT_USER]);
    ck("len", 5, wb[31:16]);
    ck("used_ev", 1, used_seen);
    ck("frame_ev", 1, frame_seen);
  endtask : t_basic
  task automatic t_cont();
    run(mk(1, 0, 1, 0), 3, 0, 1);
    ck("used_ev", 0, used_seen);
    ck("frame_ev", 1, frame_seen);
    ck("owner", 1, wb[hrd_pkg::BIT_EMPTY]);
    ck("cont", 1, wb[hrd_pkg::BIT_CONT]);
    ck("user", 0, wb[hrd_pkg::BIT_USER]);
    stop_cont = 1'b1;
    tick(1);
    stop_cont = 1'b0;
    run(32'h0, 2, 0, 1);
    ck("owner2", 0, wb[hrd_pkg::BIT_EMPTY]);
    ck("len2", 2, wb[31:16]);
  endtask : t_cont
  task automatic t_err();
    for (int k = 1; k < 4; k++) begin
      run(mk(1, 1, 1, 0), 4, k, 1);
      ck("last", 1, wb[hrd_pkg::BIT_LAST]);
      ck("err_bit", 1, wb[eb[k-1]]);
      ck("owner", 1, wb[hrd_pkg::BIT_EMPTY]);
      ck("frame_ev", 1, frame_seen);
    end
  endtask : t_err
  task automatic t_oversize();
    // limit 6 rounds up to 8 stored bytes of 11 sent
    lim = 16'h0006;
    run(mk(1, 1, 0, 0), 11, 0, 1);
    ck("stored", 8, stored);
    ck("oversize", 1, wb[hrd_pkg::BIT_OVERSIZE]);
    ck("last", 1, wb[hrd_pkg::BIT_LAST]);
    ck("len", 11, wb[31:16]);
    lim = 16'h0040;
  endtask : t_oversize
  task automatic t_misc();
    run(mk(0, 1, 0, 0), 3, 0, 0);
    ck("stored", 0, stored);
    hdlc_mode = 1'b0;
    run(mk(1, 1, 0, 0), 2, 0, 1);
    ck("last", 0, wb[hrd_pkg::BIT_LAST]);
    ck("frame_ev", 0, frame_seen);
    ck("used_ev", 1, used_seen);
    hdlc_mode = 1'b1;
  endtask : t_misc
  // bytes spaced as on a slow channel; 66 bytes fill one 64-byte buffer and open a second
  task automatic t_multi();
    lim = 16'h0100;
    gap = 4;
    run(mk(1, 1, 0, 0), 66, 0, 1);
    ck("stored", 66, stored);
    ck("writes", 2, writes);
    ck("first_len", 16'h0040, wb0[31:16]);
    ck("first_last", 0, wb0[hrd_pkg::BIT_LAST]);
    ck("first_first", 1, wb0[hrd_pkg::BIT_FIRST]);
    ck("first_owner", 0, wb0[hrd_pkg::BIT_EMPTY]);
    ck("len", 16'h0042, wb[31:16]);
    ck("first", 0, wb[hrd_pkg::BIT_FIRST]);
    ck("last", 1, wb[hrd_pkg::BIT_LAST]);
    gap = 1;
    lim = 16'h0040;
  endtask : t_multi
  initial begin
    tick(4);
    rst = 1'b0;
    tick(1);
    t_basic();
    t_cont();
    t_err();
    t_oversize();
    t_misc();
    t_multi();
    final_report();
  end
endmodule : hrd_rx_status_test
`default_nettype wire
